// ### dss_pkg.sv
/*
 * dss_pkg: constants, types and the register map of the loop sticky
 * status bank.
 * Assumes one 125 MHz clock domain and a 32-bit Avalon-MM slave port
 * whose byte address is four times the register index.
 */
// Function
// - fast-lock phase bits 3..0 latch per loop
// - fast-lock freq bits 3..0 latch; 7..4 reserved
// - flag reads 0 when nothing unacknowledged
// - time error write bits 3..0 latch; 7..4 reserved
// - monitor layout 7,6,5,1,0; bits 4..2 reserved
// - phase slope limit flag latches
// - phase memory limit flag latches
// - range limit flag latches
// - holdover and lock loss flags latch
package dss_pkg;

   // ==========================================================
   // bus geometry
   localparam int DSS_ADDR_W = 12;
   localparam int DSS_DATA_W = 32;
   localparam int DSS_REG_W = 8;
   localparam int DSS_NUM_FLAG = 5;

   // ==========================================================
   // register indices (byte address = index * 4)
   localparam logic [9:0] DSS_IDX_LOOP2_MON = 10'h198;
   localparam logic [9:0] DSS_IDX_LOOP3_MON = 10'h199;
   localparam logic [9:0] DSS_IDX_FL_PHASE = 10'h1A6;
   localparam logic [9:0] DSS_IDX_FL_FREQ = 10'h1A8;
   localparam logic [9:0] DSS_IDX_TIE_WR = 10'h1AA;
   localparam logic [9:0] DSS_IDX_IRQ_STATUS = 10'h1B8;
   localparam logic [9:0] DSS_IDX_IRQ_CLEAR = 10'h1B9;
   localparam logic [9:0] DSS_IDX_IRQ_ENABLE = 10'h1BA;

   // flag registers in bank order, element 0 is loop2 monitor
   localparam logic [DSS_NUM_FLAG-1:0][9:0] DSS_FLAG_IDX = {
      DSS_IDX_TIE_WR, DSS_IDX_FL_FREQ, DSS_IDX_FL_PHASE,
      DSS_IDX_LOOP3_MON, DSS_IDX_LOOP2_MON};

   // ==========================================================
   // implemented-bit masks and reset values
   localparam logic [7:0] DSS_MON_MASK = 8'hE3;
   localparam logic [7:0] DSS_LOOP_MASK = 8'h0F;
   localparam logic [DSS_NUM_FLAG-1:0][7:0] DSS_FLAG_MASK = {
      DSS_LOOP_MASK, DSS_LOOP_MASK, DSS_LOOP_MASK,
      DSS_MON_MASK, DSS_MON_MASK};
   localparam logic [7:0] DSS_FLAG_RESET = 8'h00;
   localparam logic [4:0] DSS_IRQ_RESET = 5'h00;
   localparam logic [31:0] DSS_READ_UNMAPPED = 32'h0000_0000;

   // ==========================================================
   // monitor field positions
   localparam int DSS_BIT_PSL = 7;
   localparam int DSS_BIT_PML = 6;
   localparam int DSS_BIT_RANGE = 5;
   localparam int DSS_BIT_HOLDOVER = 1;
   localparam int DSS_BIT_LOCK_LOSS = 0;

   // ==========================================================
   // types
   // one loop's monitor events, packed in register bit order
   typedef struct packed {
      logic psl_hit;
      logic pml_hit;
      logic range_hit;
      logic [2:0] unused;
      logic holdover_entry_flag;
      logic lock_loss;
   } dss_mon_ev_t;

   // per-loop events, bit n belongs to loop n
   typedef struct packed {
      logic [3:0] fast_lock_phase;
      logic [3:0] fast_lock_freq;
      logic [3:0] time_error_write;
   } dss_loop_ev_t;

endpackage : dss_pkg

// ### dss_sticky_reg.sv
/*
 * dss_sticky_reg: a row of sticky bits that set on an event and clear
 * on a write of one.
 * Assumes set and clear come from logic on the same clock.
 */
`timescale 1ns/1ns
module dss_sticky_reg
   import dss_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] MASK = '1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] set,
   input wire logic [WIDTH-1:0] clr,
   output logic [WIDTH-1:0] q
);

   // ==========================================================
   // storage
   // set beats clear so an event in the acknowledge cycle is kept
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         q <= RESET_VAL;
      end else begin
         q <= ((q & ~clr) | set) & MASK;
      end
   end

endmodule : dss_sticky_reg

// ### dss_sticky_bank.sv
/*
 * dss_sticky_bank: sticky status bank for four loops, with interrupt
 * status, clear and enable registers, on an Avalon-MM slave.
 * Assumes event inputs come from monitor logic on ref_clk; an event
 * held high for several cycles simply keeps its bit set.
 */
`timescale 1ns/1ns
module dss_sticky_bank
   import dss_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [DSS_ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [DSS_DATA_W-1:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [DSS_DATA_W-1:0] readdata,
   output logic waitrequest,
   input wire dss_mon_ev_t loop2_mon_ev,
   input wire dss_mon_ev_t loop3_mon_ev,
   input wire dss_loop_ev_t loop_ev,
   output logic irq
);

   // ==========================================================
   // bus handshake
   logic [9:0] word_idx;
   logic aligned;
   logic req;
   logic accept;
   logic wr_ok;

   // every access takes exactly one wait cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         waitrequest <= 1'b1;
      end else if (req && waitrequest) begin
         waitrequest <= 1'b0;
      end else begin
         waitrequest <= 1'b1;
      end
   end

   // decode of the shared address fields
   assign word_idx = address[11:2];
   assign aligned = (address[1:0] == 2'h0);
   assign req = read || write;
   assign accept = req && !waitrequest;
   // only byte lane 0 carries register data
   assign wr_ok = write && accept && aligned && byteenable[0];

   // ==========================================================
   // event vectors in register layout
   logic [DSS_NUM_FLAG-1:0][7:0] set_vec;
   logic [DSS_NUM_FLAG-1:0][7:0] clr_vec;
   logic [DSS_NUM_FLAG-1:0][7:0] flags;
   logic [DSS_NUM_FLAG-1:0] flag_hit;
   logic [DSS_NUM_FLAG-1:0] group_ev;

   // monitor fields land on bits 7,6,5,1,0; the rest are masked
   assign set_vec[0] = loop2_mon_ev;
   assign set_vec[1] = loop3_mon_ev;
   assign set_vec[2] = {4'h0, loop_ev.fast_lock_phase};
   assign set_vec[3] = {4'h0, loop_ev.fast_lock_freq};
   assign set_vec[4] = {4'h0, loop_ev.time_error_write};

   // ==========================================================
   // flag registers
   genvar r;
   generate
      for (r = 0; r < DSS_NUM_FLAG; r = r + 1) begin : g_flag
         // write of one acknowledges only the bits written
         assign flag_hit[r] = aligned && (word_idx == DSS_FLAG_IDX[r]);
         assign clr_vec[r] = (wr_ok && flag_hit[r]) ?
            writedata[7:0] : 8'h00;
         assign group_ev[r] = |(set_vec[r] & DSS_FLAG_MASK[r]);

         dss_sticky_reg #(
            .WIDTH(8),
            .MASK(DSS_FLAG_MASK[r]),
            .RESET_VAL(DSS_FLAG_RESET)
         ) u_flag (
            .ref_clk(ref_clk),
            .rst(rst),
            .set(set_vec[r]),
            .clr(clr_vec[r]),
            .q(flags[r])
         );
      end
   endgenerate

   // ==========================================================
   // interrupt status, clear and enable
   logic [4:0] irq_status;
   logic [4:0] irq_enable;
   logic [4:0] irq_clr;
   logic hit_irq_status;
   logic hit_irq_clear;
   logic hit_irq_enable;

   assign hit_irq_status = aligned && (word_idx == DSS_IDX_IRQ_STATUS);
   assign hit_irq_clear = aligned && (word_idx == DSS_IDX_IRQ_CLEAR);
   assign hit_irq_enable = aligned && (word_idx == DSS_IDX_IRQ_ENABLE);
   assign irq_clr = (wr_ok && hit_irq_clear) ? writedata[4:0] : 5'h00;

   // one status bit per flag register, set by any new event in it
   dss_sticky_reg #(
      .WIDTH(5),
      .MASK(5'h1F),
      .RESET_VAL(DSS_IRQ_RESET)
   ) u_irq_status (
      .ref_clk(ref_clk),
      .rst(rst),
      .set(group_ev),
      .clr(irq_clr),
      .q(irq_status)
   );

   // enable register steers the interrupt output
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq_enable <= DSS_IRQ_RESET;
      end else if (wr_ok && hit_irq_enable) begin
         irq_enable <= writedata[4:0];
      end
   end

   // output lags status by one cycle to keep it a clean flop
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_enable);
      end
   end

   // ==========================================================
   // read path
   logic [DSS_DATA_W-1:0] next_readdata;
   logic [7:0] flag_rd;

   // reserved bits are already zero inside the sticky rows
   always_comb begin
      flag_rd = 8'h00;
      for (int i = 0; i < DSS_NUM_FLAG; i++) begin
         if (flag_hit[i]) begin
            flag_rd = flags[i];
         end
      end
   end

   // unmapped and write-only addresses read as zero
   always_comb begin
      if (|flag_hit) begin
         next_readdata = {24'h000000, flag_rd};
      end else if (hit_irq_status) begin
         next_readdata = {27'h0000000, irq_status};
      end else if (hit_irq_enable) begin
         next_readdata = {27'h0000000, irq_enable};
      end else begin
         next_readdata = DSS_READ_UNMAPPED;
      end
   end

   // data is captured in the wait cycle and stands at the accept edge
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         readdata <= DSS_READ_UNMAPPED;
      end else if (read && waitrequest) begin
         readdata <= next_readdata;
      end
   end

endmodule : dss_sticky_bank

// ### dss_sticky_bank_asserts.sv
/* dss_sticky_bank_asserts: read-path checker for the sticky bank.
 * Assumes it is bound to dss_sticky_bank and sees only its ports. */
`timescale 1ns/1ns
module dss_bank_chk
   import dss_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [DSS_ADDR_W-1:0] address,
   input wire logic read,
   input wire logic [DSS_DATA_W-1:0] readdata,
   input wire logic waitrequest,
   input wire dss_mon_ev_t loop2_mon_ev,
   input wire dss_mon_ev_t loop3_mon_ev,
   input wire dss_loop_ev_t loop_ev
);
   // ==============================================================
   // read completions
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // accepted read of one register index
   sequence rd_at(logic [9:0] idx);
      read && !waitrequest && address[11:2] == idx;
   endsequence
   // no accept two edges back, so no clear could undo the event
   property seen(logic [9:0] idx, logic ev, int b);
      rd_at(idx) ##0 ($past(ev, 3) && $past(waitrequest, 2))
         |-> readdata[b];
   endproperty
   psl_seen_a: assert property (seen(DSS_IDX_LOOP2_MON,
      loop2_mon_ev.psl_hit, 7)) else $error("slope flag missed");
   pml_seen_a: assert property (seen(DSS_IDX_LOOP3_MON,
      loop3_mon_ev.pml_hit, 6)) else $error("memory flag missed");
   range_seen_a: assert property (seen(DSS_IDX_LOOP2_MON,
      loop2_mon_ev.range_hit, 5)) else $error("range flag missed");
   hold_seen_a: assert property (seen(DSS_IDX_LOOP3_MON,
      loop3_mon_ev.holdover_entry_flag, 1))
      else $error("holdover flag missed");
   loss_seen_a: assert property (seen(DSS_IDX_LOOP2_MON,
      loop2_mon_ev.lock_loss, 0)) else $error("lock loss flag missed");
   phase_seen_a: assert property (seen(DSS_IDX_FL_PHASE,
      loop_ev.fast_lock_phase[3], 3)) else $error("phase missed");
   freq_seen_a: assert property (seen(DSS_IDX_FL_FREQ,
      loop_ev.fast_lock_freq[0], 0)) else $error("freq missed");
   tie_seen_a: assert property (seen(DSS_IDX_TIE_WR,
      loop_ev.time_error_write[2], 2)) else $error("tie missed");
   mon_rsv_a: assert property (rd_at(DSS_IDX_LOOP2_MON) or
      rd_at(DSS_IDX_LOOP3_MON) |-> readdata[4:2] == 3'h0)
      else $error("monitor reserved bits set");
   loop_rsv_a: assert property (rd_at(DSS_IDX_FL_PHASE) or
      rd_at(DSS_IDX_FL_FREQ) or rd_at(DSS_IDX_TIE_WR)
      |-> readdata[7:4] == 4'h0) else $error("loop reserved bits set");
endmodule : dss_bank_chk
bind dss_sticky_bank dss_bank_chk u_chk(.ref_clk, .rst, .address, .read,
   .readdata, .waitrequest, .loop2_mon_ev, .loop3_mon_ev, .loop_ev);

// ### dss_sticky_bank_bench.sv
/* dss_sticky_bank_bench: random events and clears against a model.
 * Assumes one clock and one wait cycle per access. */
`timescale 1ns/1ns
module dss_sticky_bank_bench
   import dss_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [11:0] address = '0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = '0;
   logic [31:0] readdata, q;
   logic [3:0] byteenable = 4'hF;
   logic waitrequest, irq;
   dss_mon_ev_t loop2_mon_ev = '0, loop3_mon_ev = '0;
   dss_loop_ev_t loop_ev = '0;
   int exp_f[5], st, en, n_errors, tests_run, cyc;
   // ==============================================================
   // clock, design and helpers
   always #4 ref_clk = ~ref_clk;
   dss_sticky_bank u_dut(.ref_clk, .rst, .address, .read, .write,
      .writedata, .byteenable, .readdata, .waitrequest, .loop2_mon_ev,
      .loop3_mon_ev, .loop_ev, .irq);
   task chk(input logic [31:0] got, input logic [31:0] want);
      tests_run++;
      if (got !== want) begin
         n_errors++;
         $display("mismatch at %0t got %h want %h", $time, got, want);
      end
   endtask : chk
   // request held until waitrequest is sampled low
   task bus(input logic w, input logic [9:0] i, input logic [31:0] d,
      input logic [3:0] be);
      @(posedge ref_clk);
      address <= {i, 2'b00};
      read <= !w;
      write <= w;
      writedata <= d;
      byteenable <= be;
      do @(posedge ref_clk); while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask : bus
   // one-cycle event pulse; model ignores reserved bits
   task fire(input int r, input logic [7:0] v);
      @(posedge ref_clk);
      case (r)
         0: loop2_mon_ev <= v;
         1: loop3_mon_ev <= v;
         2: loop_ev.fast_lock_phase <= v[3:0];
         3: loop_ev.fast_lock_freq <= v[3:0];
         default: loop_ev.time_error_write <= v[3:0];
      endcase
      exp_f[r] |= v & DSS_FLAG_MASK[r];
      if ((v & DSS_FLAG_MASK[r]) != 0) st |= 1 << r;
      @(posedge ref_clk);
      loop2_mon_ev <= '0;
      loop3_mon_ev <= '0;
      loop_ev <= '0;
   endtask : fire
   task read_all;
      for (int i = 0; i < 5; i++) begin
         bus(1'b0, DSS_FLAG_IDX[i], 32'h0, 4'hF);
         chk(q, exp_f[i]);
      end
   endtask : read_all
   task close_out;
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out
   // hang guard, well above the ~2150 cycles the run needs
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         close_out;
      end
   end
   // ==============================================================
   // main sequence
   initial begin
      int r, m;
      void'($urandom(32'h36773af3));
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      read_all;
      for (int k = 0; k < 60; k++) begin
         r = $urandom % 5;
         fire(r, 8'($urandom));
         bus(1'b0, DSS_FLAG_IDX[r], 32'h0, 4'hF);
         chk(q, exp_f[r]);
         read_all;
         r = $urandom % 5;
         m = $urandom;
         bus(1'b1, DSS_FLAG_IDX[r], m, {3'h0, m[8]});
         if (m[8]) exp_f[r] &= ~m;
         m = $urandom;
         bus(1'b1, DSS_IDX_IRQ_ENABLE, m, 4'hF);
         en = m & 31;
         m = $urandom;
         bus(1'b1, DSS_IDX_IRQ_CLEAR, m, 4'hF);
         st &= ~m;
         bus(1'b0, DSS_IDX_IRQ_STATUS, 32'h0, 4'hF);
         chk(q, st);
         bus(1'b0, 10'h000, 32'h0, 4'hF);
         chk(q, 32'h0);
         chk({31'h0, irq}, {31'h0, (st & en) != 0});
         $display("test %0d done", k);
      end
      // flags left set must all drop on a mid-run reset
      for (int i = 0; i < 5; i++) fire(i, 8'hFF);
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++) exp_f[i] = 0;
      st = 0;
      en = 0;
      read_all;
      bus(1'b0, DSS_IDX_IRQ_STATUS, 32'h0, 4'hF);
      chk(q, st);
      $display("test reset done");
      close_out;
   end
endmodule : dss_sticky_bank_bench
